// *** include/spr_consts.vh ***
`ifndef SPR_CONSTS_VH
`define SPR_CONSTS_VH
// Register offsets
`define SPR_ADDR_DATA 8'hC5
`define SPR_ADDR_CTRL 8'hC3
`define SPR_ADDR_STAT 8'hC4
// Control fields
`define SPR_CTRL_RATE_HI 7
`define SPR_CTRL_EN 6
`define SPR_CTRL_SSOVR 5
`define SPR_CTRL_ROLE_MASTER 4
`define SPR_CTRL_CLK_IDLE_LEVEL 3
`define SPR_CTRL_CLK_SAMPLE_EDGE 2
`define SPR_CTRL_RATE_MID 1
`define SPR_CTRL_RATE_LO 0
`define SPR_CTRL_RESET 8'h14
// Status fields
`define SPR_STAT_DONE 7
`define SPR_STAT_WRITE_COLLISION_FLAG 6
`define SPR_STAT_SELECT_ERROR_FLAG 5
`define SPR_STAT_MODE_FAULT_FLAG 4
`define SPR_STAT_RESV 4'h0
// Half-period counter tops per rate code
`define SPR_DIV_R1 7'h01
`define SPR_DIV_R2 7'h03
`define SPR_DIV_R3 7'h07
`define SPR_DIV_R4 7'h0F
`define SPR_DIV_R5 7'h1F
`define SPR_DIV_R6 7'h3F
`define SPR_DIV_RSVD 7'h7F
// Last of the sixteen half periods of a byte
`define SPR_HALF_LAST 4'hF
`endif

// *** logic/spr_serial_peripheral.v ***
`timescale 1ns/100ps
`include "spr_consts.vh"
module spr_serial_peripheral #(
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire reset,
  input wire [ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData,
  input wire sckIn,
  output reg sckOut,
  output reg sckOe,
  input wire mosiIn,
  output reg mosiOut,
  output reg mosiOe,
  input wire misoIn,
  output reg misoOut,
  output reg misoOe,
  input wire selectN
);
  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;

  reg [7:0] ctrl_r;
  reg [7:0] shift_r;
  reg [7:0] rxBuf_r;
  reg done_r;
  reg write_collision_flag_r;
  reg select_error_flag_r;
  reg mode_fault_flag_r;
  reg state_r;
  reg [3:0] half_r;
  reg [6:0] div_r;
  reg sckLvl_r;
  reg sckPrev_r;
  reg sampled_r;
  reg statRead_r;
  reg doneRead_r;
  reg [6:0] divTop;
  reg [2:0] rate;
  wire en = ctrl_r[`SPR_CTRL_EN];
  wire master = ctrl_r[`SPR_CTRL_ROLE_MASTER];
  wire clk_idle_level = ctrl_r[`SPR_CTRL_CLK_IDLE_LEVEL];
  wire clk_sample_edge = ctrl_r[`SPR_CTRL_CLK_SAMPLE_EDGE];
  wire ssOvr = ctrl_r[`SPR_CTRL_SSOVR];
  // Slave with phase zero always needs select to frame bytes
  wire ssUsed = !ssOvr || (!master && !clk_sample_edge);
  wire selActive = ssUsed ? !selectN : 1'b1;
  wire wrData = regWrStb && regAddr == `SPR_ADDR_DATA;
  wire wrCtrl = regWrStb && regAddr == `SPR_ADDR_CTRL;
  wire rdData = regRdStb && regAddr == `SPR_ADDR_DATA;
  wire rdStat = regRdStb && regAddr == `SPR_ADDR_STAT;
  wire rateOk = rate != 3'b000 && rate != 3'b111;
  wire busy = state_r == ST_XFER;
  wire divHit = div_r == divTop;
  // Slave edge detect on the incoming clock, relative to idle level
  wire sckEdge = sckIn != sckPrev_r;
  wire sckLeave = sckEdge && sckIn != clk_idle_level;
  wire inBit = master ? misoIn : mosiIn;
  wire modfEvt = en && master && !ssOvr && !selectN;
  wire sserrEvt = en && !master && busy && ssUsed && selectN;
  // Edge classes for both roles; for master use internal toggles
  wire mEdge = master && busy && divHit;
  wire edgeNow = master ? mEdge : (busy || sckLeave) && sckEdge && selActive;
  wire leaving = master ? (sckLvl_r == clk_idle_level) : sckLeave;
  wire sampleEdge = edgeNow && (leaving ^ clk_sample_edge);
  wire shiftEdge = edgeNow && !(leaving ^ clk_sample_edge);
  wire lastHalf = half_r == `SPR_HALF_LAST;
  wire loadIdle = wrData && !busy;
  wire startMaster = en && loadIdle && master && rateOk;
  wire startSlave = en && !master && !busy && selActive && sckLeave;
  wire xferEnd = en && edgeNow && lastHalf;
  // Phase zero slave loses its byte framing once deselected
  wire abortSlave = en && !master && !clk_sample_edge && busy && selectN;
  // In phase one the first leaving edge only presents data
  wire skipFirst = clk_sample_edge && half_r == 4'h0 && leaving;
  wire doneClr = (wrData || rdData) && doneRead_r;
  wire [7:0] statWord = {done_r, write_collision_flag_r, select_error_flag_r, mode_fault_flag_r, `SPR_STAT_RESV};
  wire [7:0] rxNext = clk_sample_edge ? {shift_r[6:0], inBit} : {shift_r[6:0], sampled_r};

  always @*
  begin
    rate = {ctrl_r[`SPR_CTRL_RATE_HI], ctrl_r[`SPR_CTRL_RATE_MID], ctrl_r[`SPR_CTRL_RATE_LO]};
    // Half period in clocks: divide by 2^(rate+1), half is 2^rate
    case (rate)
      3'b001: divTop = `SPR_DIV_R1;
      3'b010: divTop = `SPR_DIV_R2;
      3'b011: divTop = `SPR_DIV_R3;
      3'b100: divTop = `SPR_DIV_R4;
      3'b101: divTop = `SPR_DIV_R5;
      3'b110: divTop = `SPR_DIV_R6;
      default: divTop = `SPR_DIV_RSVD;
    endcase
  end

  // Edge history for the slave clock input
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sckPrev_r <= 1'b0;
    end
    else
      sckPrev_r <= sckIn;
  end

  // Read data stands one cycle; all other cycles read zero
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      regRdData <= 8'h00;
    end
    else if (regRdStb)
    begin
      // Unmapped addresses read zero rather than stale data
      case (regAddr)
        `SPR_ADDR_DATA: regRdData <= rxBuf_r;
        `SPR_ADDR_STAT: regRdData <= statWord;
        `SPR_ADDR_CTRL: regRdData <= ctrl_r;
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

  // A status read with collision or fault set arms their clearing
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      statRead_r <= 1'b0;
    end
    else if (rdStat)
      statRead_r <= write_collision_flag_r || mode_fault_flag_r;
  end

  // Done clears on a status read followed by a data access
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      doneRead_r <= 1'b0;
    end
    else if (doneClr)
      doneRead_r <= 1'b0;
    else if (rdStat)
      doneRead_r <= done_r;
  end

  // Mode fault drops enable and role even against a same-cycle write
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= `SPR_CTRL_RESET;
    end
    else
    begin
      if (wrCtrl)
        ctrl_r <= regWrData;
      if (modfEvt)
      begin
        ctrl_r[`SPR_CTRL_EN] <= 1'b0;
        ctrl_r[`SPR_CTRL_ROLE_MASTER] <= 1'b0;
      end
    end
  end

  // Disable kills the byte mid-flight, no completion
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
    end
    else if (!en)
      state_r <= ST_IDLE;
    else
    begin
      if (startMaster || startSlave)
        state_r <= ST_XFER;
      if (xferEnd || abortSlave || modfEvt)
        state_r <= ST_IDLE;
    end
  end

  // Counts the sixteen clock edges of one byte
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      half_r <= 4'h0;
    end
    else if (!en)
      half_r <= 4'h0;
    else if (edgeNow)
      half_r <= half_r + 4'h1;
    else if (loadIdle)
      half_r <= 4'h0;
  end

  // Divider runs only while a master byte is on the wire
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      div_r <= 7'h00;
    end
    else if (!en)
      div_r <= 7'h00;
    else if (master && busy)
      div_r <= divHit ? 7'h00 : div_r + 7'h01;
    else if (loadIdle)
      div_r <= 7'h00;
  end

  // Serial clock parks at its idle level whenever no byte runs
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sckLvl_r <= 1'b0;
    end
    else if (!en || !busy)
      sckLvl_r <= clk_idle_level;
    else if (mEdge)
      sckLvl_r <= !sckLvl_r;
  end

  // A data write while enabled and idle goes straight into the shifter
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      shift_r <= 8'h00;
    end
    else if (en && shiftEdge && !skipFirst)
      shift_r <= {shift_r[6:0], sampled_r};
    else if (en && loadIdle)
      shift_r <= regWrData;
  end

  // Holds the bit taken on the sampling edge until the next shift
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sampled_r <= 1'b0;
    end
    else if (en && sampleEdge)
      sampled_r <= inBit;
    else if (en && loadIdle)
      sampled_r <= 1'b0;
  end

  // Receive buffer only changes when a byte completes
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rxBuf_r <= 8'h00;
    end
    else if (xferEnd)
      rxBuf_r <= rxNext;
  end

  // Set wins over a same-cycle clear
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      done_r <= 1'b0;
    end
    else if (xferEnd)
      done_r <= 1'b1;
    else if (doneClr)
      done_r <= 1'b0;
  end

  // Collision never stops the running byte
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      write_collision_flag_r <= 1'b0;
    end
    else if (wrData && busy)
      write_collision_flag_r <= 1'b1;
    else if (wrData && statRead_r)
      write_collision_flag_r <= 1'b0;
  end

  // Only a disable clears the select error
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      select_error_flag_r <= 1'b0;
    end
    else if (!en)
      select_error_flag_r <= 1'b0;
    else if (sserrEvt)
      select_error_flag_r <= 1'b1;
  end

  // Fault clears on a status read followed by a control write
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_fault_flag_r <= 1'b0;
    end
    else if (modfEvt)
      mode_fault_flag_r <= 1'b1;
    else if (wrCtrl && statRead_r)
      mode_fault_flag_r <= 1'b0;
  end

  // Pin drivers come from flops to avoid glitches on the link
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sckOut <= 1'b0;
      sckOe <= 1'b0;
    end
    else
    begin
      sckOut <= sckLvl_r;
      sckOe <= en && master;
    end
  end

  // Data pins turn with the role so two drivers never meet
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
    end
    else
    begin
      mosiOut <= shift_r[7];
      mosiOe <= en && master;
      misoOut <= shift_r[7];
      misoOe <= en && !master && selActive;
    end
  end
endmodule // spr_serial_peripheral

// *** test/spr_serial_peripheral_asserts.sv ***
`timescale 1ns/100ps
module spr_serial_peripheral_asserts #(parameter ADDR_W = 8) (
  input wire ref_clk,
  input wire reset,
  input wire [ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  input wire [7:0] regRdData,
  input wire sckOut,
  input wire sckOe,
  input wire mosiOe,
  input wire misoOe,
  input wire selectN
);
  reg [7:0] ctlR;
  always @(posedge ref_clk or posedge reset)
    if (reset)
      ctlR <= 8'h14;
    else
    begin
      if (regWrStb && regAddr == 8'hC3)
        ctlR <= regWrData;
      // A mode fault drops enable and role, over any same-cycle write
      if (ctlR[6] && ctlR[4] && !ctlR[5] && !selectN)
      begin
        ctlR[6] <= 1'b0;
        ctlR[4] <= 1'b0;
      end
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence rdOf(a);
    $past(regRdStb) && $past(regAddr) == a;
  endsequence
  chk_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00) else $error("rd idle");
  chk_ctrl_readback: assert property (rdOf(8'hC3) |-> regRdData == $past(ctlR)) else $error("ctrl");
  chk_resv_bits_zero: assert property (rdOf(8'hC4) |-> regRdData[3:0] == 4'h0) else $error("resv");
  chk_unmapped_zero: assert property (rdOf(8'h00) |-> regRdData == 8'h00) else $error("unmapped");
  chk_role_oe_excl: assert property (!(mosiOe && misoOe)) else $error("role");
  chk_master_oe_pair: assert property (sckOe == mosiOe) else $error("sck oe");
  chk_sck_half_min: assert property (sckOe && $changed(sckOut) |=> $stable(sckOut)) else $error("rate");
  chk_disable_drops_oe: assert property (regWrStb && regAddr == 8'hC3 && !regWrData[6]
    |-> ##2 !sckOe && !mosiOe && !misoOe) else $error("disable");
endmodule // spr_serial_peripheral_asserts
bind spr_serial_peripheral spr_serial_peripheral_asserts #(.ADDR_W(ADDR_W)) chk (.ref_clk(ref_clk),
  .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .sckOut(sckOut), .sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe), .selectN(selectN));

// *** test/spr_spi_partner.sv ***
`timescale 1ns/100ps
module spr_spi_partner (
  input wire sck,
  input wire mosi,
  input wire [7:0] txByte,
  output reg miso,
  output reg [7:0] rxByte
);
  reg [2:0] bitIdx = 3'h0;
  initial miso = 1'b0;
  always @(posedge sck)
    miso <= txByte[3'h7 - bitIdx];
  always @(negedge sck)
  begin
    rxByte <= {rxByte[6:0], mosi};
    bitIdx <= bitIdx + 3'h1;
    // Line stays driven between bytes; inverting keeps stale data from passing
    if (bitIdx == 3'h7)
      miso <= ~miso;
  end
endmodule // spr_spi_partner

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, e); end end
module tb_top;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] regWrData = 8'h00;
  reg regWrStb = 1'b0;
  reg regRdStb = 1'b0;
  reg selectN = 1'b1;
  wire [7:0] regRdData, rxByte;
  wire sckOut, sckOe, mosiOut, mosiOe, misoIn;
  reg [7:0] d;
  int error_cnt = 0, checks_done = 0, cycles = 0, i, n;
  initial forever #5 ref_clk = ~ref_clk;
  // Slave clock and data tied: only the master role shifts here
  spr_serial_peripheral DUT (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .sckIn(1'b0), .sckOut(sckOut),
    .sckOe(sckOe), .mosiIn(1'b0), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(),
    .misoOe(), .selectN(selectN));
  spr_spi_partner peer (.sck(sckOut), .mosi(mosiOut), .txByte(8'h3C), .miso(misoIn), .rxByte(rxByte));
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  end
  endtask
  task print_verdict;
  begin
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'hC3); `CHK(d, 8'h14)
    rd(8'hC4); `CHK(d & 8'hD0, 8'h00)
    rd(8'h00); `CHK(d, 8'h00)
    for (i = 6; i > 0; i--)
    begin
      wr(8'hC3, {i[2], 5'h15, i[1:0]});
      wr(8'hC5, 8'hA5);
      n = 0;
      while (sckOut !== 1'b1 && n < 300) begin @(posedge ref_clk); n++; end
      n = 0;
      while (sckOut === 1'b1 && n < 300) begin @(posedge ref_clk); n++; end
      `CHK(n, 1 << i)
      if (i == 6) wr(8'hC5, 8'hFF);
      d = 8'h00;
      n = 0;
      while (d[7] !== 1'b1 && n < 1000) begin rd(8'hC4); n++; end
      `CHK(d, i == 6 ? 8'hC0 : 8'h80)
      rd(8'hC5); `CHK(d, 8'h3C)
      `CHK(rxByte, 8'hA5)
    end
    wr(8'hC3, 8'h54);
    wr(8'hC5, 8'hA5);
    repeat (40) @(posedge ref_clk);
    rd(8'hC4); `CHK(d, 8'h00)
    wr(8'hC3, 8'h56);
    wr(8'hC5, 8'h11);
    repeat (20) @(posedge ref_clk);
    wr(8'hC3, 8'h16);
    repeat (1100) @(posedge ref_clk);
    `CHK({sckOe, mosiOe}, 2'b00)
    rd(8'hC4); `CHK(d, 8'h00)
    wr(8'hC3, 8'h5E);
    repeat (3) @(posedge ref_clk);
    `CHK({sckOe, sckOut}, 2'b11)
    selectN <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(8'hC4); `CHK(d, 8'h10)
    rd(8'hC3); `CHK(d, 8'h0E)
    wr(8'hC3, 8'h7E);
    rd(8'hC4); `CHK(d, 8'h00)
    rd(8'hC3); `CHK(d, 8'h7E)
    print_verdict;
  end
endmodule // tb_top
